// ==== dma_channel_mode_upper_bits_test.sv ====
`timescale 1ns/10ps
module dma_channel_mode_upper_bits_test;
  import dma_mode_pkg::*;
  localparam logic [31:0] BASE = 32'h0000004B, HI = 32'h5A5A_0000, DIE = 32'h0000_0400;
  localparam logic [31:0] DEM = 32'h1000, INV = 32'h2000, EOTE = 32'h4000, FAST = 32'h8000;
  localparam logic [31:0] CLR = 32'h1_0000, PCI = 32'h2_0000, DAC = 32'h4_0000;
  localparam logic [31:0] ENDL = 32'h8_0000, SG = 32'h0200;
  logic i_clock = 0, i_rst = 1, i_reg_write = 0, i_reg_read = 0, i_start = 0, i_irq_clear = 0;
  logic i_chan0_eot_enable = 0, i_fifo_almost_full = 0, req_on = 0, eot_go = 0, stall = 0;
  logic [7:0] i_reg_addr = 0, i_cache_line_size_reg = 0;
  logic [31:0] i_reg_wdata = 0, i_dma_high_address_reg = 32'hC3C3_0011, o_reg_rdata;
  logic [22:0] i_block_count = 0, first_count = 23'h000008, i_desc_count;
  bus_variant_t i_bus_variant = BUS_NONMUX;
  logic o_busy, o_desc_req, i_desc_valid, i_desc_last, o_desc_clear, i_desc_clear_ack;
  logic i_local_ready, o_local_xfer, o_dma_acknowledge_out_n, o_last_transfer_out_n;
  logic o_burst_in_progress_out_n, i_dma_request_in_n, i_end_of_transfer_in_n;
  logic o_end_of_transfer_out, o_end_of_transfer_oe, o_pci_invalidate, o_inta_n;
  logic o_local_interrupt_out_n;
  logic [31:0] i_desc_high_addr, o_pci_high_addr;
  logic [4:0] o_pci_burst_lwords;
  int error_cnt = 0, total_checks = 0, beats, acks, lasts, bursts, descs, clears;

  always #2.5 i_clock = ~i_clock;
  dma_channel_one dut_u (.i_clock, .i_rst, .i_reg_write, .i_reg_read, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .i_bus_variant, .i_cache_line_size_reg,
    .i_dma_high_address_reg, .i_chan0_eot_enable, .i_fifo_almost_full, .i_start,
    .i_block_count, .i_irq_clear, .o_busy, .o_desc_req, .i_desc_valid, .i_desc_count,
    .i_desc_high_addr, .i_desc_last, .o_desc_clear, .i_desc_clear_ack, .i_local_ready,
    .o_local_xfer, .o_dma_acknowledge_out_n, .o_last_transfer_out_n,
    .o_burst_in_progress_out_n, .i_dma_request_in_n, .i_end_of_transfer_in_n,
    .o_end_of_transfer_out, .o_end_of_transfer_oe, .o_pci_high_addr, .o_pci_invalidate,
    .o_pci_burst_lwords, .o_inta_n, .o_local_interrupt_out_n);
  dma_peripheral_model #(.HIGH_BASE(HI)) peer_u (.i_clock, .i_rst, .i_rewind(i_start),
    .i_req_on(req_on), .i_eot_go(eot_go), .i_stall(stall), .i_first_count(first_count),
    .i_desc_req(o_desc_req), .i_desc_clear(o_desc_clear), .o_desc_valid(i_desc_valid),
    .o_desc_count(i_desc_count), .o_desc_high_addr(i_desc_high_addr),
    .o_desc_last(i_desc_last), .o_desc_clear_ack(i_desc_clear_ack),
    .o_local_ready(i_local_ready), .o_dma_request_in_n(i_dma_request_in_n),
    .o_end_of_transfer_in_n(i_end_of_transfer_in_n));

  // tally of port activity during one transfer
  always @(posedge i_clock) begin
    beats  += (o_local_xfer === 1'b1);
    acks   += (o_dma_acknowledge_out_n === 1'b0);
    lasts  += (o_last_transfer_out_n === 1'b0);
    bursts += (o_burst_in_progress_out_n === 1'b0);
    descs  += (o_desc_req === 1'b1 && i_desc_valid === 1'b1);
    clears += (o_desc_clear === 1'b1 && i_desc_clear_ack === 1'b1);
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    #1 d = o_reg_rdata;
  endtask : rd

  task automatic pulse_clear();
    @(posedge i_clock);
    i_irq_clear <= 1'b1;
    @(posedge i_clock);
    i_irq_clear <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask : pulse_clear

  // hold/drop/eot_at: cycle after start at which request rises, falls, end pin fires
  task automatic run(input logic [31:0] mode, input logic [22:0] cnt, input int hold,
                     input int drop, input int eot_at);
    int n;
    wr(8'h94, mode);
    @(posedge i_clock);
    req_on <= (hold == 0);
    repeat (6) @(posedge i_clock);
    i_block_count <= cnt;
    i_start <= 1'b1;
    beats = 0; acks = 0; lasts = 0; bursts = 0; descs = 0; clears = 0;
    @(posedge i_clock);
    i_start <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
      if (n == hold) begin
        chk("beats while request idle", beats, 0);
        req_on <= 1'b1;
      end
      if (n == drop) req_on <= 1'b0;
      eot_go <= (n >= eot_at && n < eot_at + 6);
      #1;
    end while (o_busy === 1'b1 && n < 5000);
    chk("run finished", o_busy, 1'b0);
    @(posedge i_clock);
    eot_go <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask : run

  task automatic t_regs();
    logic [31:0] d;
    rd(8'h94, d);
    chk("mode reset", d, BASE);
    chk("irq lines idle", {o_inta_n, o_local_interrupt_out_n, o_busy}, 3'b110);
    for (int b = 12; b < 20; b++) begin
      wr(8'h94, 32'hFFC0_004B | (32'h1 << b));
      rd(8'h94, d);
      chk("mode bit readback", d, BASE | (32'h1 << b));
    end
    wr(8'h90, 32'hFFFF_FFFF);
    rd(8'h90, d);
    chk("unmapped read", d, 32'h0);
  endtask : t_regs

  task automatic t_inval();
    logic [7:0] cls[4] = '{8'h08, 8'h10, 8'h04, 8'h20};
    logic [4:0] len[4] = '{5'h08, 5'h10, 5'h00, 5'h00};
    wr(8'h94, BASE | INV);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      i_cache_line_size_reg <= cls[k];
      repeat (3) @(posedge i_clock);
      chk("invalidate on", o_pci_invalidate, k < 2);
      chk("burst lwords", o_pci_burst_lwords, len[k]);
    end
  endtask : t_inval

  task automatic t_pin();
    wr(8'h94, BASE);
    @(posedge i_clock);
    i_fifo_almost_full <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk("pin drives status", {o_end_of_transfer_oe, o_end_of_transfer_out}, 2'b11);
    i_fifo_almost_full <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk("status follows fifo", o_end_of_transfer_out, 1'b0);
    wr(8'h94, BASE | EOTE);
    repeat (2) @(posedge i_clock);
    chk("pin is input", o_end_of_transfer_oe, 1'b0);
    wr(8'h94, BASE);
    i_chan0_eot_enable <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk("other channel holds pin", o_end_of_transfer_oe, 1'b0);
    i_chan0_eot_enable <= 1'b0;
  endtask : t_pin

  task automatic t_block();
    run(BASE | DIE | PCI, 23'h000008, 0, 0, 9999);
    chk("block beats", beats, 2);
    chk("last beat marked", lasts, 1);
    chk("no acknowledge", acks, 0);
    chk("pci irq", {o_inta_n, o_local_interrupt_out_n}, 2'b01);
    pulse_clear();
    i_bus_variant <= BUS_MUX;
    run((BASE & ~32'h3) | 32'h1 | DEM | DIE, 23'h000008, 0, 0, 9999);
    chk("half-word beats", beats, 4);
    chk("last beat muxed", lasts, 1);
    chk("local irq", {o_inta_n, o_local_interrupt_out_n}, 2'b10);
    pulse_clear();
    i_bus_variant <= BUS_NONMUX;
  endtask : t_block

  task automatic t_demand();
    stall <= 1'b1;
    run((BASE & ~32'h3) | DEM, 23'h000004, 20, 0, 9999);
    chk("byte beats per word", beats, 4);
    chk("acknowledged beats", acks, 4);
    stall <= 1'b0;
    run(BASE | DEM | FAST, 23'h000190, 0, 10, 9999);
    chk("request drop ends", beats < 100, 1'b1);
  endtask : t_demand

  task automatic t_proc();
    i_bus_variant <= BUS_PROC;
    run(BASE, 23'h000020, 0, 0, 9999);
    chk("burst marked slow", bursts != 0, 1'b1);
    run(BASE | FAST, 23'h000020, 0, 0, 9999);
    chk("burst off fast", bursts, 0);
    run(BASE | FAST | EOTE, 23'h000190, 0, 0, 10);
    chk("fast end", beats < 100, 1'b1);
    run(BASE | EOTE, 23'h000190, 0, 0, 10);
    chk("slow end at line", {beats < 100, beats[1:0]}, 3'b100);
    i_bus_variant <= BUS_NONMUX;
  endtask : t_proc

  task automatic t_sg();
    run(BASE | SG | CLR | DAC | DIE, 23'h0, 0, 0, 9999);
    chk("links fetched", descs, 2);
    chk("counts cleared", clears, 2);
    chk("sg beats", beats, 4);
    chk("desc high", o_pci_high_addr, HI + 32'h1);
    chk("irq after clear", o_local_interrupt_out_n, 1'b0);
    pulse_clear();
    run(BASE | SG, 23'h0, 0, 0, 9999);
    chk("reg high", o_pci_high_addr, i_dma_high_address_reg);
    chk("no clears", clears, 0);
    first_count <= 23'h000190;
    run(BASE | SG | EOTE | FAST, 23'h0, 0, 0, 10);
    chk("chain ended", descs, 1);
    run(BASE | SG | EOTE | FAST | ENDL, 23'h0, 0, 0, 10);
    chk("link ended only", {descs == 2, beats < 102}, 2'b11);
  endtask : t_sg

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_inval();
    t_pin();
    t_block();
    t_demand();
    t_proc();
    t_sg();
    conclude();
  end

  // the whole sequence needs well under 20000 cycles
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule : dma_channel_mode_upper_bits_test

// ==== dma_channel_one.sv ====
//
// Notes on behaviour
// - demand mode moves data only while the request pin is asserted.
// - acknowledge pin marks each local transfer made for the request.
// - demand mode moves 32-bit words, split into beats on 8/16-bit buses.
// - invalidate bit issues write-and-invalidate with 8 or 16 lword bursts.
// - any other cache line size falls back to plain memory writes.
// - bit 14 enables the end-of-transfer pin for this channel.
// - both channels' enables clear turns the pin into fifo almost-full output.
// - processor bus slow stop drops burst-in-progress at 16-byte boundary.
// - processor bus fast stop disables burst-in-progress, stops at once.
// - local bus variants slow stop assert last-transfer on final beat.
// - local bus variants fast stop end at once on pin or request drop.
// - clear-count mode zeroes each descriptor byte count when done.
// - bit 17 routes interrupt to pci line, else local interrupt output.
// - bit 18 takes high address from descriptor, else high-address register.
// - with bit 19 set, end-of-transfer ends only the current link.
// - with bit 19 clear, end-of-transfer ends the whole chain.
// - scatter/gather bit selects descriptor-driven operation, else block mode.
// - in clear-count mode done interrupt waits until the count is cleared.
`timescale 1ns/10ps
`include "dma_mode_map.svh"
module dma_channel_one (
  // clock and reset
  input  wire logic                       i_clock,
  input  wire logic                       i_rst,
  // register port
  input  wire logic                       i_reg_write,
  input  wire logic                       i_reg_read,
  input  wire logic [7:0]                 i_reg_addr,
  input  wire logic [31:0]                i_reg_wdata,
  output logic [31:0]                     o_reg_rdata,
  // configuration from neighbouring registers
  input  wire dma_mode_pkg::bus_variant_t i_bus_variant,
  input  wire logic [7:0]                 i_cache_line_size_reg,
  input  wire logic [31:0]                i_dma_high_address_reg,
  input  wire logic                       i_chan0_eot_enable,
  input  wire logic                       i_fifo_almost_full,
  // channel control
  input  wire logic                       i_start,
  input  wire logic [22:0]                i_block_count,
  input  wire logic                       i_irq_clear,
  output logic                            o_busy,
  // descriptor fetch and count clear
  output logic                            o_desc_req,
  input  wire logic                       i_desc_valid,
  input  wire logic [22:0]                i_desc_count,
  input  wire logic [31:0]                i_desc_high_addr,
  input  wire logic                       i_desc_last,
  output logic                            o_desc_clear,
  input  wire logic                       i_desc_clear_ack,
  // local bus side
  input  wire logic                       i_local_ready,
  output logic                            o_local_xfer,
  output logic                            o_dma_acknowledge_out_n,
  output logic                            o_last_transfer_out_n,
  output logic                            o_burst_in_progress_out_n,
  // pins to and from the peripheral, inputs active low
  input  wire logic                       i_dma_request_in_n,
  input  wire logic                       i_end_of_transfer_in_n,
  output logic                            o_end_of_transfer_out,
  output logic                            o_end_of_transfer_oe,
  // pci side
  output logic [31:0]                     o_pci_high_addr,
  output logic                            o_pci_invalidate,
  output logic [4:0]                      o_pci_burst_lwords,
  output logic                            o_inta_n,
  output logic                            o_local_interrupt_out_n
);
  import dma_mode_pkg::*;

  function automatic logic [2:0] beat_bytes(input logic [1:0] width);
    case (width)
      2'h0:    beat_bytes = 3'h1;
      2'h1:    beat_bytes = 3'h2;
      default: beat_bytes = 3'h4;
    endcase
  endfunction : beat_bytes

  ////////////////////////////////////////////////////////////////////////////
  // mode register
  logic [`MODE_BITS-1:0] mode, next_mode;
  logic [31:0]           rdata, next_rdata;
  logic                  hit;

  always_comb begin
    hit        = (i_reg_addr == `MODE1_OFFSET);
    next_mode  = mode;
    next_rdata = rdata;
    if (i_reg_write && hit) begin
      next_mode = i_reg_wdata[`MODE_BITS-1:0];
    end
    if (i_reg_read) begin
      next_rdata = hit ? {10'h000, mode} : 32'h00000000;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode  <= `MODE_RESET;
      rdata <= 32'h00000000;
    end else begin
      mode  <= next_mode;
      rdata <= next_rdata;
    end
  end

  assign o_reg_rdata = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // pins
  logic dreq_lvl, eot_lvl;
  logic dreq_on, eot_on, eot_prev, eot_rise;

  pin_sync #(.RESET_LEVEL(1'b1)) u_dreq_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_pin   (i_dma_request_in_n),
    .o_level (dreq_lvl)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_eot_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_pin   (i_end_of_transfer_in_n),
    .o_level (eot_lvl)
  );

  assign dreq_on  = ~dreq_lvl;
  assign eot_on   = ~eot_lvl & mode[`F_EOT_EN];
  assign eot_rise = eot_on & ~eot_prev;

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine
  chan_state_t state, next_state;
  logic [22:0] count, next_count;
  logic [3:0]  offset, next_offset;
  logic [31:0] high_addr, next_high_addr;
  logic        last_desc, next_last_desc;
  logic        stop_pend, next_stop_pend;
  logic        eot_ended, next_eot_ended;
  logic        link_done, after_done, demand, fast, sg, proc, go, final_beat;
  logic        fast_stop, slow_end, boundary, done_set;
  logic [2:0]  step;
  logic [4:0]  off_sum;

  always_comb begin
    demand    = mode[`F_DEMAND];
    fast      = mode[`F_FAST_TERM];
    sg        = mode[`F_SG];
    proc      = (i_bus_variant == BUS_PROC);
    step      = beat_bytes(mode[1:0]);
    off_sum   = {1'b0, offset} + {2'b00, step};
    boundary  = (off_sum[3:0] == 4'h0);
    final_beat = (count <= {20'h00000, step});
    // slow termination: request drop only pauses, the pin ends the link
    go        = (state == ST_XFER) && i_local_ready && (!demand || dreq_on);
    fast_stop = (state == ST_XFER) && fast && (eot_rise || (demand && !dreq_on));
    slow_end  = (stop_pend || eot_rise) && (proc ? boundary : 1'b1);
    link_done = 1'b0;
    next_state     = state;
    next_count     = count;
    next_offset    = offset;
    next_high_addr = high_addr;
    next_last_desc = last_desc;
    next_stop_pend = stop_pend;
    next_eot_ended = eot_ended;
    done_set       = 1'b0;
    case (state)
      ST_IDLE: begin
        next_stop_pend = 1'b0;
        next_eot_ended = 1'b0;
        next_offset    = 4'h0;
        if (i_start) begin
          if (sg) begin
            next_state = ST_FETCH;
          end else begin
            next_state     = ST_XFER;
            next_count     = i_block_count;
            next_high_addr = i_dma_high_address_reg;
            next_last_desc = 1'b1;
          end
        end
      end
      ST_FETCH: begin
        if (i_desc_valid) begin
          next_state     = ST_XFER;
          next_count     = i_desc_count;
          next_last_desc = i_desc_last;
          next_stop_pend = 1'b0;
          next_eot_ended = 1'b0;
          next_high_addr = mode[`F_DAC_LOAD] ? i_desc_high_addr : i_dma_high_address_reg;
        end
      end
      ST_XFER: begin
        if (fast_stop) begin
          link_done      = 1'b1;
          next_eot_ended = eot_rise;
        end else if (count == 23'h000000) begin
          link_done = 1'b1;
        end else begin
          if (eot_rise) begin
            next_stop_pend = 1'b1;
          end
          if (go) begin
            next_count  = final_beat ? 23'h000000 : count - {20'h00000, step};
            next_offset = off_sum[3:0];
            if (final_beat || slow_end) begin
              link_done      = 1'b1;
              next_eot_ended = stop_pend || eot_rise;
            end
          end
        end
      end
      ST_CLEAR: begin
        if (i_desc_clear_ack) begin
          link_done = 1'b1;
        end
      end
      ST_DONE: begin
        done_set   = mode[`F_DONE_IE];
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // after a link: in clear-count scatter/gather mode clear its count, then chain on or finish
    after_done = (next_eot_ended && !mode[`F_EOT_END_LINK]) || next_last_desc;
    if (link_done) begin
      if (state == ST_XFER && sg && mode[`F_CLEAR_COUNT]) begin
        next_state = ST_CLEAR;
      end else if (!sg || after_done) begin
        next_state = ST_DONE;
      end else begin
        next_state = ST_FETCH;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state     <= ST_IDLE;
      count     <= 23'h000000;
      offset    <= 4'h0;
      high_addr <= 32'h00000000;
      last_desc <= 1'b0;
      stop_pend <= 1'b0;
      eot_ended <= 1'b0;
      eot_prev  <= 1'b0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      offset    <= next_offset;
      high_addr <= next_high_addr;
      last_desc <= next_last_desc;
      stop_pend <= next_stop_pend;
      eot_ended <= next_eot_ended;
      eot_prev  <= eot_on;
    end
  end

  // handshake outputs follow the beat decision in the same cycle
  always_comb begin
    o_local_xfer              = go && !fast_stop && (count != 23'h000000);
    o_dma_acknowledge_out_n   = ~(o_local_xfer && demand);
    o_last_transfer_out_n     = ~(o_local_xfer && !proc && (final_beat || slow_end));
    o_burst_in_progress_out_n = ~((state == ST_XFER) && proc && !fast);
    o_desc_req                = (state == ST_FETCH);
    o_desc_clear              = (state == ST_CLEAR);
    o_busy                    = (state != ST_IDLE);
    o_pci_high_addr           = high_addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pci write mode and pin reuse
  logic       inval, next_inval, pin_oe, next_pin_oe, pin_out, next_pin_out;
  logic [4:0] burst, next_burst;
  logic       cls_ok;

  always_comb begin
    cls_ok       = (i_cache_line_size_reg == `CLS_8_LWORDS) ||
                   (i_cache_line_size_reg == `CLS_16_LWORDS);
    next_inval   = mode[`F_INVALIDATE] && cls_ok;
    next_burst   = next_inval ? i_cache_line_size_reg[4:0] : 5'h00;
    next_pin_oe  = !mode[`F_EOT_EN] && !i_chan0_eot_enable;
    next_pin_out = next_pin_oe && i_fifo_almost_full;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      inval   <= 1'b0;
      burst   <= 5'h00;
      pin_oe  <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      inval   <= next_inval;
      burst   <= next_burst;
      pin_oe  <= next_pin_oe;
      pin_out <= next_pin_out;
    end
  end

  assign o_pci_invalidate      = inval;
  assign o_pci_burst_lwords    = burst;
  assign o_end_of_transfer_oe  = pin_oe;
  assign o_end_of_transfer_out = pin_out;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt
  dma_irq_route u_irq (
    .i_clock                 (i_clock),
    .i_rst                   (i_rst),
    .i_set                   (done_set),
    .i_clear                 (i_irq_clear),
    .i_to_pci                (mode[`F_IRQ_TO_PCI]),
    .o_inta_n                (o_inta_n),
    .o_local_interrupt_out_n (o_local_interrupt_out_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_demand_gate: assert property (o_local_xfer && demand |-> dreq_on)
    else $error("demand transfer without request");
  chk_ack_marks: assert property (o_local_xfer && demand |-> !o_dma_acknowledge_out_n)
    else $error("acknowledge missing on demand transfer");
  chk_lane_split: assert property (o_local_xfer && mode[1:0] == 2'h0 && count > 23'h4
    |=> count == $past(count) - 23'h1)
    else $error("8-bit beat did not move one byte");
  chk_invalidate_size: assert property (o_pci_invalidate |-> $past(mode[`F_INVALIDATE]) &&
    ($past(i_cache_line_size_reg) == `CLS_8_LWORDS || $past(i_cache_line_size_reg) == `CLS_16_LWORDS))
    else $error("invalidate with bad cache line size");
  chk_pin_reuse: assert property (!$past(i_rst) |-> o_end_of_transfer_oe ==
    ($past(!mode[`F_EOT_EN]) && $past(!i_chan0_eot_enable)))
    else $error("pin reuse does not follow enables");
  chk_fast_stop: assert property (fast_stop |=> state != ST_XFER)
    else $error("fast termination did not stop");
  chk_burst_in_progress_out_boundary: assert property ($past(stop_pend) && $rose(o_burst_in_progress_out_n)
    && proc |-> offset == 4'h0)
    else $error("burst ended off a 16-byte boundary");
  chk_last_local: assert property (!o_last_transfer_out_n |-> !proc && o_local_xfer)
    else $error("last transfer outside a local beat");
  chk_clear_first: assert property (state == ST_DONE && $past(state) != ST_IDLE && sg
    && mode[`F_CLEAR_COUNT] |-> $past(state) == ST_CLEAR)
    else $error("done before count clear");
  chk_chain_stop: assert property (state == ST_FETCH && $past(state) == ST_XFER
    |-> !eot_ended || mode[`F_EOT_END_LINK])
    else $error("chain continued after end-of-transfer");
endmodule : dma_channel_one

// ==== dma_irq_route.sv ====
`timescale 1ns/10ps
module dma_irq_route (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // event, clear and routing select
  input  wire logic i_set,
  input  wire logic i_clear,
  input  wire logic i_to_pci,
  // interrupt lines, active low
  output logic      o_inta_n,
  output logic      o_local_interrupt_out_n
);
  logic pending, inta_n, lint_n;
  logic next_pending, next_inta_n, next_lint_n;

  // set wins over a clear in the same cycle
  always_comb begin
    next_pending = i_set | (pending & ~i_clear);
    next_inta_n  = ~(next_pending & i_to_pci);
    next_lint_n  = ~(next_pending & ~i_to_pci);
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pending <= 1'b0;
      inta_n  <= 1'b1;
      lint_n  <= 1'b1;
    end else begin
      pending <= next_pending;
      inta_n  <= next_inta_n;
      lint_n  <= next_lint_n;
    end
  end

  assign o_inta_n                = inta_n;
  assign o_local_interrupt_out_n = lint_n;

  chk_route_select: assert property (@(posedge i_clock) disable iff (i_rst)
    i_set |=> (!o_inta_n == $past(i_to_pci)) && (!o_local_interrupt_out_n == !$past(i_to_pci)))
    else $error("interrupt not routed by select bit");
endmodule : dma_irq_route

// ==== dma_mode_map.svh ====
`ifndef DMA_MODE_MAP_SVH
`define DMA_MODE_MAP_SVH
// register offset and implemented width
`define MODE1_OFFSET      8'h94
`define MODE_BITS         22
`define MODE_RESET        22'h00004B
// field positions
`define F_WIDTH_LO        0
`define F_SG              9
`define F_DONE_IE         10
`define F_DEMAND          12
`define F_INVALIDATE      13
`define F_EOT_EN          14
`define F_FAST_TERM       15
`define F_CLEAR_COUNT     16
`define F_IRQ_TO_PCI      17
`define F_DAC_LOAD        18
`define F_EOT_END_LINK    19
// cache line sizes that allow write-and-invalidate
`define CLS_8_LWORDS      8'h08
`define CLS_16_LWORDS     8'h10
`endif

// ==== dma_mode_pkg.sv ====
package dma_mode_pkg;
  typedef enum {ST_IDLE, ST_FETCH, ST_XFER, ST_CLEAR, ST_DONE} chan_state_t;
  typedef enum logic [1:0] {BUS_PROC, BUS_NONMUX, BUS_MUX} bus_variant_t;
endpackage : dma_mode_pkg

// ==== dma_peripheral_model.sv ====
`timescale 1ns/10ps
module dma_peripheral_model #(
  parameter logic [31:0] HIGH_BASE = 32'h5A5A_0000
) (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // commands from the bench
  input  wire logic        i_rewind,
  input  wire logic        i_req_on,
  input  wire logic        i_eot_go,
  input  wire logic        i_stall,
  input  wire logic [22:0] i_first_count,
  // descriptor side of the channel
  input  wire logic        i_desc_req,
  input  wire logic        i_desc_clear,
  output logic             o_desc_valid,
  output logic [22:0]      o_desc_count,
  output logic [31:0]      o_desc_high_addr,
  output logic             o_desc_last,
  output logic             o_desc_clear_ack,
  // local bus and pins, pins active low
  output logic             o_local_ready,
  output logic             o_dma_request_in_n,
  output logic             o_end_of_transfer_in_n
);
  logic idx;
  logic [22:0] cnt;
  logic [31:0] hi;
  assign cnt = idx ? 23'h000008 : i_first_count;
  assign hi  = HIGH_BASE + {31'h0, idx};
  // fields go to their inverted value outside valid so stale values are never taken
  assign o_desc_count     = o_desc_valid ? cnt : ~cnt;
  assign o_desc_high_addr = o_desc_valid ? hi : ~hi;
  assign o_desc_last      = o_desc_valid ? idx : ~idx;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      idx                    <= 1'b0;
      o_desc_valid           <= 1'b0;
      o_desc_clear_ack       <= 1'b0;
      o_local_ready          <= 1'b1;
      o_dma_request_in_n     <= 1'b1;
      o_end_of_transfer_in_n <= 1'b1;
    end else begin
      o_dma_request_in_n     <= ~i_req_on;
      o_end_of_transfer_in_n <= ~i_eot_go;
      o_local_ready          <= i_stall ? ~o_local_ready : 1'b1;
      o_desc_valid           <= i_desc_req & ~o_desc_valid;
      o_desc_clear_ack       <= i_desc_clear & ~o_desc_clear_ack;
      if (i_rewind) begin
        idx <= 1'b0;
      end else if (o_desc_valid & i_desc_req) begin
        idx <= 1'b1;
      end
    end
  end
endmodule : dma_peripheral_model

// ==== pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // pin and settled level
  input  wire logic i_pin,
  output logic      o_level
);
  logic ff1, ff2, ff3, level;
  logic next_level;

  // a change only counts once the second and third stages agree
  always_comb begin
    next_level = (ff2 == ff3) ? ff3 : level;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ff1   <= RESET_LEVEL;
      ff2   <= RESET_LEVEL;
      ff3   <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end else begin
      ff1   <= i_pin;
      ff2   <= ff1;
      ff3   <= ff2;
      level <= next_level;
    end
  end

  assign o_level = level;
endmodule : pin_sync
